//--- rtl/spi_flags_pkg.sv
// Package of constants and types for the serial port buffer-full flag block
// How it works
// - Standard: core write to data location sets tx full (bit 1).
// - Standard: holding buffer moving into shifter clears tx full.
// - Enhanced: tx full sets when a write takes the last free entry.
// - Enhanced: tx full clears as soon as one entry is free.
// - Standard: finished word into holding buffer sets rx full (bit 0).
// - Standard: core read of the data location clears rx full.
// - Enhanced: rx full sets when a transfer fills the last unread entry.
// - Enhanced: rx full clears whenever an entry is free for the shifter.
package spi_flags_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [11:0] AddrStat    = 12'h000;
    localparam logic [11:0] AddrCtrl    = 12'h004;
    localparam logic [11:0] AddrData    = 12'h008;
    localparam logic [11:0] AddrIrqStat = 12'h00c;
    localparam logic [11:0] AddrIrqEn   = 12'h010;
    localparam logic [11:0] AddrIrqClr  = 12'h014;
    localparam logic [11:0] AddrXfer    = 12'h018;
    localparam logic [11:0] AddrRxIn    = 12'h01c;

    localparam int RbfBit    = 0;
    localparam int TbfBit    = 1;
    localparam int EnhBit    = 0;
    localparam int TxCntLsb  = 8;
    localparam int RxCntLsb  = 12;
    localparam int XferStart = 0;

    localparam int DataW  = 16;
    localparam int Depth  = 8;
    localparam int PtrW   = 3;
    localparam int CntW   = 4;
    localparam int IrqW   = 4;
    localparam int IrqTxFull = 0;
    localparam int IrqTxFree = 1;
    localparam int IrqRxFull = 2;
    localparam int IrqRxOver = 3;

    localparam logic [CntW-1:0] CntDepth = 4'h8;
    localparam logic [CntW-1:0] CntOne   = 4'h1;
    localparam logic [PtrW-1:0] PtrOne   = 3'h1;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [Depth-1:0][DataW-1:0] mem;
        logic [PtrW-1:0]             wrPtr;
        logic [PtrW-1:0]             rdPtr;
        logic [CntW-1:0]             cnt;
    } queue_t;

    typedef struct packed {
        logic            psel;
        logic            penable;
        logic            pwrite;
        logic [11:0]     paddr;
        logic [31:0]     pwdata;
    } apb_req_t;

    typedef struct packed {
        logic [31:0]     prdata;
        logic            pready;
        logic            pslverr;
    } apb_rsp_t;
endpackage

//--- rtl/flag_queue.sv
// Small word queue with full flag used for both buffer directions
`timescale 1ns/100ps
module flag_queue
    import spi_flags_pkg::*;
(
    input  wire logic             clk,
    input  wire logic             resetn,
    input  wire logic             enhanced,
    input  wire logic             push,
    input  wire logic [DataW-1:0] pushData,
    input  wire logic             pop,
    output logic      [DataW-1:0] head,
    output logic                  notEmpty,
    output logic                  full,
    output logic      [CntW-1:0]  count
);
    queue_t st_q;
    queue_t st_d;

    logic [CntW-1:0] cap;
    logic            doPush;
    logic            doPop;

    always_comb begin
        cap    = enhanced ? CntDepth : CntOne;
        doPop  = pop && (st_q.cnt != '0);
        doPush = push && ((st_q.cnt != cap) || doPop);
        st_d   = st_q;
        if (doPush) begin
            st_d.mem[st_q.wrPtr] = pushData;
            st_d.wrPtr = enhanced ? st_q.wrPtr + PtrOne : st_q.rdPtr;
        end
        if (doPop) begin
            st_d.rdPtr = enhanced ? st_q.rdPtr + PtrOne : st_q.rdPtr;
        end
        if (doPush && !doPop) begin
            st_d.cnt = st_q.cnt + CntOne;
        end else if (doPop && !doPush) begin
            st_d.cnt = st_q.cnt - CntOne;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign head     = st_q.mem[st_q.rdPtr];
    assign notEmpty = st_q.cnt != '0;
    assign full     = st_q.cnt == cap;
    assign count    = st_q.cnt;
endmodule

//--- rtl/spi_buffer_full_flags.sv
// Buffer-full flag logic of the serial port with APB registers
//
// Local design decisions: the APB slave port and the register addresses.
`timescale 1ns/100ps
module spi_buffer_full_flags
    import spi_flags_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             txLoad,
    output logic [DataW-1:0] txWord,
    output logic             irq
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        apb_rsp_t         rsp;
        logic             enh;
        logic [IrqW-1:0]  irqStat;
        logic [IrqW-1:0]  irqEn;
        logic             irq;
        logic             txLoad;
        logic [DataW-1:0] txWord;
        logic             tbfPrev;
        logic             rbfPrev;
    } state_t;

    state_t st_q;
    state_t st_d;

    apb_req_t req;
    logic     access;
    logic     wrAcc;
    logic     rdAcc;

    logic             txPush;
    logic             txPop;
    logic [DataW-1:0] txHead;
    logic             txAvail;
    logic             txFull;
    logic [CntW-1:0]  txCnt;
    logic             rxPush;
    logic             rxPop;
    logic [DataW-1:0] rxHead;
    logic             rxAvail;
    logic             rxFull;
    logic [CntW-1:0]  rxCnt;
    logic [15:0]      statWord;
    logic [IrqW-1:0]  events;

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    always_comb begin
        req.psel    = psel;
        req.penable = penable;
        req.pwrite  = pwrite;
        req.paddr   = paddr;
        req.pwdata  = pwdata;
    end

    assign access = req.psel && req.penable;
    assign wrAcc  = access && req.pwrite;
    assign rdAcc  = access && !req.pwrite;

    // ------------------------------------------------------------
    // Transmit side
    // ------------------------------------------------------------
    assign txPush = wrAcc && (req.paddr == AddrData);
    assign txPop  = wrAcc && (req.paddr == AddrXfer)
                    && req.pwdata[XferStart];

    flag_queue txQueue (
        .clk      (clk),
        .resetn   (resetn),
        .enhanced (st_q.enh),
        .push     (txPush),
        .pushData (req.pwdata[DataW-1:0]),
        .pop      (txPop),
        .head     (txHead),
        .notEmpty (txAvail),
        .full     (txFull),
        .count    (txCnt)
    );

    // ------------------------------------------------------------
    // Receive side
    // ------------------------------------------------------------
    assign rxPush = wrAcc && (req.paddr == AddrRxIn);
    assign rxPop  = rdAcc && (req.paddr == AddrData);

    flag_queue rxQueue (
        .clk      (clk),
        .resetn   (resetn),
        .enhanced (st_q.enh),
        .push     (rxPush),
        .pushData (req.pwdata[DataW-1:0]),
        .pop      (rxPop),
        .head     (rxHead),
        .notEmpty (rxAvail),
        .full     (rxFull),
        .count    (rxCnt)
    );

    // ------------------------------------------------------------
    // Status word
    // ------------------------------------------------------------
    always_comb begin
        statWord         = '0;
        statWord[TbfBit] = txFull;
        statWord[RbfBit] = rxFull;
        statWord[TxCntLsb +: CntW] = txCnt;
        statWord[RxCntLsb +: CntW] = rxCnt;
    end

    // ------------------------------------------------------------
    // Interrupt events
    // ------------------------------------------------------------
    always_comb begin
        events            = '0;
        events[IrqTxFull] = txFull && !st_q.tbfPrev;
        events[IrqTxFree] = !txFull && st_q.tbfPrev;
        events[IrqRxFull] = rxFull && !st_q.rbfPrev;
        events[IrqRxOver] = rxPush && rxFull && !rxPop;
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        st_d             = st_q;
        st_d.rsp.pready  = 1'b0;
        st_d.rsp.pslverr = 1'b0;
        st_d.txLoad      = 1'b0;
        st_d.tbfPrev     = txFull;
        st_d.rbfPrev     = rxFull;

        if (txPop && txAvail) begin
            st_d.txLoad = 1'b1;
            st_d.txWord = txHead;
        end

        if (req.psel && !req.penable) begin
            st_d.rsp.pready = 1'b1;
            st_d.rsp.prdata = '0;
            if (!req.pwrite) begin
                case (req.paddr)
                    AddrStat:    st_d.rsp.prdata[15:0] = statWord;
                    AddrCtrl:    st_d.rsp.prdata[EnhBit] = st_q.enh;
                    AddrData:    st_d.rsp.prdata[DataW-1:0] = rxHead;
                    AddrIrqStat: st_d.rsp.prdata[IrqW-1:0] = st_q.irqStat;
                    AddrIrqEn:   st_d.rsp.prdata[IrqW-1:0] = st_q.irqEn;
                    AddrIrqClr:  st_d.rsp.prdata = '0;
                    AddrXfer:    st_d.rsp.prdata = '0;
                    AddrRxIn:    st_d.rsp.prdata = '0;
                    default:     st_d.rsp.pslverr = 1'b1;
                endcase
            end else begin
                case (req.paddr)
                    AddrStat, AddrCtrl, AddrData, AddrIrqStat,
                    AddrIrqEn, AddrIrqClr, AddrXfer, AddrRxIn: begin
                        st_d.rsp.pslverr = 1'b0;
                    end
                    default: st_d.rsp.pslverr = 1'b1;
                endcase
            end
        end

        if (wrAcc && req.paddr == AddrCtrl) begin
            st_d.enh = req.pwdata[EnhBit];
        end
        if (wrAcc && req.paddr == AddrIrqEn) begin
            st_d.irqEn = req.pwdata[IrqW-1:0];
        end
        if (wrAcc && req.paddr == AddrIrqClr) begin
            st_d.irqStat = st_q.irqStat & ~req.pwdata[IrqW-1:0];
        end
        st_d.irqStat = st_d.irqStat | events;
        st_d.irq     = |(st_d.irqStat & st_d.irqEn);
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign prdata  = st_q.rsp.prdata;
    assign pready  = st_q.rsp.pready;
    assign pslverr = st_q.rsp.pslverr;
    assign txLoad  = st_q.txLoad;
    assign txWord  = st_q.txWord;
    assign irq     = st_q.irq;
endmodule

//--- dv/spi_flags_checker.sv
// Port checker of the buffer-full flag block
`timescale 1ns/100ps
module spi_flags_checker
    import spi_flags_pkg::*;
(
    input wire logic             clk,
    input wire logic             resetn,
    input wire logic             psel,
    input wire logic             penable,
    input wire logic             pwrite,
    input wire logic [11:0]      paddr,
    input wire logic [31:0]      pwdata,
    input wire logic [31:0]      prdata,
    input wire logic             pready,
    input wire logic             pslverr,
    input wire logic             txLoad,
    input wire logic [DataW-1:0] txWord,
    input wire logic             irq
);
    // ----
    // Last transfer and mode
    // ----
    logic        enhQ;
    logic        lastWrQ;
    logic [11:0] lastAddrQ;
    logic        stat;
    logic        std;
    assign stat = pready & !pwrite & !pslverr & paddr == AddrStat;
    assign std = stat & !enhQ;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            enhQ      <= 1'b0;
            lastWrQ   <= 1'b0;
            lastAddrQ <= AddrStat;
        end else if (psel && penable && pready) begin
            lastWrQ   <= pwrite;
            lastAddrQ <= paddr;
            if (pwrite && paddr == AddrCtrl) enhQ <= pwdata[EnhBit];
        end
    end
    // ----
    // Properties
    // ----
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    property p_rdy; psel && !penable |=> pready; endproperty
    a_rdy: assert property (p_rdy) else $error("pready late");
    property p_one; pready |=> !pready; endproperty
    a_one: assert property (p_one) else $error("pready long");
    property p_err; pready && pslverr |-> prdata == 32'h0; endproperty
    a_err: assert property (p_err) else $error("error data");
    property p_word; !$stable(txWord) |-> txLoad; endproperty
    a_word: assert property (p_word) else $error("word moved");
    property p_tbf;
        stat |-> prdata[TbfBit] == (prdata[11:8] == (enhQ ? 8 : 1));
    endproperty
    a_tbf: assert property (p_tbf) else $error("tx flag");
    property p_rbf;
        stat |-> prdata[RbfBit] == (prdata[15:12] == (enhQ ? 8 : 1));
    endproperty
    a_rbf: assert property (p_rbf) else $error("rx flag");
    property p_wset; std && lastWrQ && lastAddrQ == AddrData
        |-> prdata[TbfBit]; endproperty
    a_wset: assert property (p_wset) else $error("tx set");
    property p_rset; std && lastWrQ && lastAddrQ == AddrRxIn
        |-> prdata[RbfBit]; endproperty
    a_rset: assert property (p_rset) else $error("rx set");
    property p_rclr; std && !lastWrQ && lastAddrQ == AddrData
        |-> !prdata[RbfBit]; endproperty
    a_rclr: assert property (p_rclr) else $error("rx clear");
    c_load: cover property (txLoad);
    c_tx: cover property (std && prdata[TbfBit]);
    c_rx: cover property (stat && enhQ && prdata[RbfBit]);
endmodule

bind spi_buffer_full_flags spi_flags_checker u_spi_flags_checker (.clk,
    .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .txLoad, .txWord, .irq);

//--- dv/cpu_core_model.sv
// Core model issuing register transfers
`timescale 1ns/100ps
module cpu_core_model (
    input  wire logic        clk,
    input  wire logic        pready,
    input  wire logic        pslverr,
    input  wire logic [31:0] prdata,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic      [11:0] paddr,
    output logic      [31:0] pwdata
);
    initial {psel, penable, pwrite, paddr, pwdata} = '0;
    task automatic xfer(input logic w, input logic [11:0] a,
        input logic [31:0] d, output logic [31:0] rd,
        output logic e, output logic hung);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (!pready && n < 50);
        hung = !pready;
        rd = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~a;
        pwdata <= ~d;
    endtask
endmodule

//--- dv/spi_buffer_full_flags_tb_top.sv
// Testbench of the buffer-full flag block
`timescale 1ns/100ps
module spi_buffer_full_flags_tb_top
    import spi_flags_pkg::*;
;
    logic             clk = 1'b0;
    logic             resetn = 1'b0;
    logic             psel, penable, pwrite, pready, pslverr;
    logic             txLoad, irq, err, hung, enh;
    logic [11:0]      paddr;
    logic [31:0]      pwdata, prdata, rd;
    logic [DataW-1:0] txWord;
    logic [31:0]      expV[$], expM[$];
    logic [DataW-1:0] txQ[$], txExp[$], rxQ[$];
    int               errorCnt = 0, checksDone = 0, txc = 0, rxc = 0;
    always #2 clk = ~clk;
    spi_buffer_full_flags u_spi_buffer_full_flags (.clk, .resetn, .psel,
        .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .txLoad, .txWord, .irq);
    cpu_core_model u_cpu_core_model (.clk, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr);
    // ----
    // Tasks
    // ----
    task automatic chk(input string nm, input logic [31:0] seen, exp);
        checksDone++;
        if (seen !== exp) begin
            errorCnt++;
            $display("ERROR %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic finish_test();
        $display("Checks %0d errors %0d", checksDone, errorCnt);
        if (errorCnt == 0 && checksDone > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic bus(input logic w, input logic [11:0] a, input int d);
        u_cpu_core_model.xfer(w, a, d, rd, err, hung);
        if (hung) errorCnt++;
        if (hung) finish_test();
    endtask
    task automatic rdx(input logic [11:0] a, input logic [31:0] v, m);
        expV.push_back(v);
        expM.push_back(m);
        bus(1'b0, a, 0);
    endtask
    function automatic logic [31:0] stat();
        logic [CntW-1:0] d, t, r;
        d = enh ? CntDepth : CntOne;
        t = CntW'(txc);
        r = CntW'(rxc);
        return {16'h0, r, t, 6'h0, t == d, r == d};
    endfunction
    task automatic st();
        rdx(AddrStat, stat(), '1);
    endtask
    task automatic push(input logic [11:0] a);
        logic [DataW-1:0] v;
        v = DataW'($urandom);
        bus(1'b1, a, v);
        if (a == AddrData && txc < (enh ? Depth : 1)) txQ.push_back(v);
        if (a == AddrData && txc < (enh ? Depth : 1)) txc++;
        if (a == AddrRxIn && rxc < (enh ? Depth : 1)) rxQ.push_back(v);
        if (a == AddrRxIn && rxc < (enh ? Depth : 1)) rxc++;
    endtask
    task automatic xfr();
        bus(1'b1, AddrXfer, 1);
        if (txc > 0) txExp.push_back(txQ.pop_front());
        if (txc > 0) txc--;
    endtask
    task automatic pop();
        rdx(AddrData, {16'h0, rxQ.pop_front()}, 32'hffff);
        rxc--;
    endtask
    // ----
    // Result monitor
    // ----
    always @(posedge clk) begin
        logic [31:0] v, m;
        if (psel && penable && pready && !pwrite && expV.size() > 0) begin
            v = expV.pop_front();
            m = expM.pop_front();
            chk("rdata", prdata & m, v & m);
        end
        if (txLoad && txExp.size() == 0) chk("txLoad", 1, 0);
        else if (txLoad) chk("txWord", txWord, txExp.pop_front());
    end
    initial begin
        void'($urandom(21));
        enh = 1'b0;
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
        st();
        bus(1'b1, AddrIrqClr, 32'hf);
        bus(1'b1, AddrIrqEn, 32'h4);
        repeat (2) begin
            push(AddrData);
            st();
        end
        xfr();
        st();
        $display("Standard transmit done");
        push(AddrRxIn);
        st();
        chk("irq", irq, 1);
        bus(1'b1, AddrStat, 0);
        st();
        bus(1'b1, AddrStat, 32'hffffffff);
        st();
        pop();
        st();
        bus(1'b1, AddrIrqEn, 0);
        rdx(AddrIrqStat, 32'h4, 32'h4);
        chk("irq", irq, 0);
        bus(1'b1, AddrIrqClr, 32'h4);
        bus(1'b1, AddrIrqEn, 32'h4);
        rdx(AddrIrqStat, 0, 32'h4);
        chk("irq", irq, 0);
        $display("Standard receive done");
        bus(1'b1, AddrCtrl, 1);
        enh = 1'b1;
        repeat (9) begin
            push(AddrData);
            st();
        end
        repeat (8) begin
            xfr();
            st();
        end
        $display("Enhanced transmit done");
        repeat (9) begin
            push(AddrRxIn);
            st();
        end
        repeat (8) begin
            pop();
            st();
        end
        rdx(12'hffc, 0, '1);
        chk("pslverr", err, 1);
        repeat (3) @(posedge clk);
        chk("txLeft", txExp.size(), 0);
        $display("Enhanced receive done");
        finish_test();
    end
endmodule
